// file: hw/dbmpi_dram_ctrl.sv
// Design decisions made here: the register addresses and the APB register port.
`include "dbmpi_consts.svh"
module dbmpi_dram_ctrl
  import dbmpi_pkg::*;
#(
  parameter int ADDR_W = 24,
  parameter int BANKS  = 4
)(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire dbmpi_req_t  cpuReq,
  input  wire logic        cpuPipelined,
  output dbmpi_resp_t      cpuResp,
  output logic             busHandoff,
  output logic             video_buffer_access_n,
  output logic             bios_rom_select_n,
  output logic      [3:0]  rowStrobe_n,
  output logic      [3:0]  colStrobeHi_n,
  output logic      [3:0]  colStrobeLo_n,
  output logic      [9:0]  dram_mux_address,
  output logic             dram_write_strobe_n,
  output logic      [17:0] dramDataOut,
  output logic             dramDataOe,
  input  wire logic [17:0] dramDataIn
);
  localparam int RAS_CYC = `DBMPI_RAS_MAX_CYC;
  localparam int RW      = $clog2(RAS_CYC + 1);
  localparam int TRCD    = `DBMPI_TRCD_CYC;
  localparam int CAS_CYC = `DBMPI_TCAS_CYC + `DBMPI_SYNC_LAT;
  localparam int TRP     = `DBMPI_TRP_CYC;

  if (ADDR_W != 24 || BANKS != 4)
  begin : g_chk
    $error("dbmpi_dram_ctrl serves 24 address bits and four banks only");
  end

  logic rstMeta_n;
  logic rstSync_n;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      rstMeta_n <= 1'b0;
      rstSync_n <= 1'b0;
    end
    else
    begin
      rstMeta_n <= 1'b1;
      rstSync_n <= rstMeta_n;
    end

  // ---------------- register file
  logic [31:0]  cfgReg;
  logic [31:0]  shadowReg;
  logic [31:0]  statusWord;
  logic [31:0]  readMux;
  logic         apbSetup;
  logic         apbDone;
  logic         mapped;
  logic         cfgWr;
  assign apbSetup = psel && !penable;
  assign apbDone  = psel && penable && pready;
  assign mapped   = paddr == `DBMPI_REG_CFG || paddr == `DBMPI_REG_SHADOW || paddr == `DBMPI_REG_STATUS;
  assign cfgWr    = apbDone && pwrite && paddr == `DBMPI_REG_CFG;

  always_comb
  begin
    case (paddr)
      `DBMPI_REG_CFG:    readMux = cfgReg;
      `DBMPI_REG_SHADOW: readMux = shadowReg;
      `DBMPI_REG_STATUS: readMux = statusWord;
      default:           readMux = 32'h0000_0000;
    endcase
  end

  // one wait-free access phase: pready rises in the cycle after setup
  always_ff @(posedge clk or negedge rstSync_n)
    if (!rstSync_n)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= apbSetup;
      pslverr <= apbSetup && !mapped;
      if (apbSetup)
        prdata <= pwrite ? 32'h0000_0000 : readMux;
    end

  always_ff @(posedge clk or negedge rstSync_n)
    if (!rstSync_n)
    begin
      cfgReg    <= `DBMPI_CFG_RESET;
      shadowReg <= `DBMPI_SHADOW_RESET;
    end
    else if (apbDone && pwrite)
    begin
      if (paddr == `DBMPI_REG_CFG)
        cfgReg <= pwdata & `DBMPI_CFG_MASK;
      if (paddr == `DBMPI_REG_SHADOW)
        shadowReg <= pwdata & `DBMPI_SHADOW_MASK;
    end

  // ---------------- configuration
  dbmpi_mode_t  cfgMode;
  dbmpi_mode_t  modeEff;
  dbmpi_dtype_t bt [4];
  logic [23:0]  base1;
  logic [23:0]  base2;
  logic [23:0]  base3;
  logic [23:0]  total;
  logic         cfgErr;
  logic         remapOn;
  logic         shadowOk;

  function automatic logic [23:0] bankBytes(dbmpi_dtype_t t);
    case (t)
      D_64K:   bankBytes = `DBMPI_SIZE_64K;
      D_256K:  bankBytes = `DBMPI_SIZE_256K;
      D_1M:    bankBytes = `DBMPI_SIZE_1M;
      default: bankBytes = 24'h00_0000;
    endcase
  endfunction

  for (genvar g = 0; g < 4; g++)
  begin : g_type
    assign bt[g] = dbmpi_dtype_t'(cfgReg[`DBMPI_CFG_TYPE_LSB + 2 * g +: 2]);
  end

  assign cfgMode = dbmpi_mode_t'(cfgReg[`DBMPI_CFG_MODE_LSB +: 2]);
  assign base1   = bankBytes(bt[0]);
  assign base2   = 24'(base1 + bankBytes(bt[1]));
  assign base3   = 24'(base2 + bankBytes(bt[2]));
  assign total   = 24'(base3 + bankBytes(bt[3]));
  // a bad population falls back to plain linear non-page access
  assign cfgErr  = bt[0] == D_64K || bt[2] == D_64K || bt[3] == D_64K
                || (bt[1] == D_64K && bt[0] != D_256K)
                || (cfgMode == M_IL2 && (bt[0] != bt[1] || bt[2] != bt[3] || bt[0] == D_NONE))
                || (cfgMode == M_IL4 && (bt[0] != bt[1] || bt[1] != bt[2] || bt[2] != bt[3]
                                      || bt[0] == D_NONE));
  assign modeEff  = cfgErr ? M_NONPAGE : cfgMode;
  assign remapOn  = cfgReg[`DBMPI_CFG_REMAP] && total == `DBMPI_MB1;
  assign shadowOk = total >= `DBMPI_MB1;

  // ---------------- request latch and decode
  dbmpi_state_t state;
  dbmpi_state_t next_state;
  logic [23:1]  reqAddr;
  logic         reqWrite;
  logic [1:0]   reqBe;
  logic [15:0]  reqData;
  logic [23:0]  a;
  logic [23:0]  phys;
  logic [23:0]  rel;
  logic [23:0]  off;
  logic [2:0]   rng;
  logic [1:0]   bank;
  logic [9:0]   row;
  logic [9:0]   col;
  logic         isVideo;
  logic         isBios;
  logic         shOn;
  logic         wrDrop;
  logic         romSel;
  logic         dramSel;
  logic         hit;
  logic [9:0]   openRow [4];

  always_ff @(posedge clk or negedge rstSync_n)
    if (!rstSync_n)
    begin
      reqAddr  <= 23'h00_0000;
      reqWrite <= 1'b0;
      reqBe    <= 2'h0;
      reqData  <= 16'h0000;
    end
    else if (state == S_IDLE && cpuReq.valid)
    begin
      reqAddr  <= cpuReq.addr;
      reqWrite <= cpuReq.write;
      reqBe    <= cpuReq.be;
      reqData  <= cpuReq.wdata;
    end

  assign a = {reqAddr, 1'b0};

  always_comb
  begin
    isVideo = a >= `DBMPI_VID_LO && a < `DBMPI_BIOS_LO;
    isBios  = a >= `DBMPI_BIOS_LO && a < `DBMPI_MB1;
    rng     = a[17:15];
    shOn    = isBios && shadowOk && shadowReg[`DBMPI_SH_DRAMON + rng];
    wrDrop  = shOn && reqWrite && shadowReg[`DBMPI_SH_WRPROT + rng];
    romSel  = isBios && !shOn && !shadowReg[`DBMPI_SH_ROMOFF + rng];
    phys    = a;
    dramSel = 1'b0;
    if (a < `DBMPI_KB640)
      dramSel = 1'b1;
    else if (shOn)
      dramSel = !wrDrop;
    else if (a >= `DBMPI_MB1)
    begin
      dramSel = 1'b1;
      if (remapOn)
        phys = 24'(a - `DBMPI_MB1 + `DBMPI_KB640);
    end
    dramSel = dramSel && phys < total;
    rel     = phys;
    case (modeEff)
      M_IL2:
      begin
        rel  = phys >= base2 ? 24'(phys - base2) : phys;
        bank = {phys >= base2, rel[10]};
        off  = {1'b0, rel[23:11], rel[9:0]};
      end
      M_IL4:
      begin
        bank = phys[11:10];
        off  = {2'b00, phys[23:12], phys[9:0]};
      end
      default:
      begin
        bank = phys >= base3 ? 2'd3 : phys >= base2 ? 2'd2 : phys >= base1 ? 2'd1 : 2'd0;
        case (bank)
          2'd1:    off = 24'(phys - base1);
          2'd2:    off = 24'(phys - base2);
          2'd3:    off = 24'(phys - base3);
          default: off = phys;
        endcase
      end
    endcase
    case (bt[bank])
      D_64K:
      begin
        col = {2'b00, off[8:1]};
        row = {2'b00, off[16:9]};
      end
      D_1M:
      begin
        col = off[10:1];
        row = off[20:11];
      end
      default:
      begin
        col = {1'b0, off[9:1]};
        row = {1'b0, off[18:10]};
      end
    endcase
    hit = modeEff != M_NONPAGE && !rowStrobe_n[bank] && openRow[bank] == row;
  end

  // ---------------- cycle sequencer
  logic [2:0] phCnt;
  logic [2:0] preCnt [4];
  logic [RW-1:0] rasCnt [4];
  logic       busy;
  assign busy = state != S_IDLE && state != S_WAIT;

  always_comb
  begin
    next_state = state;
    case (state)
      S_IDLE: if (cpuReq.valid) next_state = cpuPipelined ? S_DEC : S_WAIT;
      S_WAIT: next_state = S_DEC;
      S_DEC:
        if (!dramSel)
          next_state = S_DONE;
        else if (hit)
          next_state = S_CAS;
        else
          next_state = S_PRE;
      S_PRE:  if (rowStrobe_n[bank] && preCnt[bank] == 3'd0) next_state = S_RAS;
      S_RAS:  if (phCnt == 3'(TRCD - 1)) next_state = S_CAS;
      S_CAS:  if (phCnt == 3'(CAS_CYC - 1)) next_state = S_DONE;
      S_DONE: next_state = S_IDLE;
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstSync_n)
    if (!rstSync_n)
    begin
      state <= S_IDLE;
      phCnt <= 3'd0;
    end
    else
    begin
      state <= next_state;
      phCnt <= next_state != state ? 3'd0 : 3'(phCnt + 3'd1);
    end

  // ---------------- per-bank row state
  for (genvar i = 0; i < 4; i++)
  begin : g_bank
    logic closeNow;
    logic openNow;
    // a configuration write closes every row, since the mapping under it may change
    assign closeNow = !rowStrobe_n[i] && (cfgWr
                   || (state == S_DEC && dramSel && !hit && bank == 2'(i))
                   || (state == S_DONE && modeEff == M_NONPAGE && bank == 2'(i))
                   || (rasCnt[i] == RW'(RAS_CYC) && !(busy && bank == 2'(i))));
    assign openNow  = next_state == S_RAS && state != S_RAS && bank == 2'(i);

    always_ff @(posedge clk or negedge rstSync_n)
      if (!rstSync_n)
        rowStrobe_n[i] <= 1'b1;
      else if (closeNow)
        rowStrobe_n[i] <= 1'b1;
      else if (openNow)
        rowStrobe_n[i] <= 1'b0;

    always_ff @(posedge clk or negedge rstSync_n)
      if (!rstSync_n)
        rasCnt[i] <= '0;
      else if (rowStrobe_n[i])
        rasCnt[i] <= '0;
      else if (rasCnt[i] != RW'(RAS_CYC))
        rasCnt[i] <= RW'(rasCnt[i] + 1'b1);

    always_ff @(posedge clk or negedge rstSync_n)
      if (!rstSync_n)
        preCnt[i] <= 3'd0;
      else if (closeNow)
        preCnt[i] <= 3'(TRP - 1);
      else if (preCnt[i] != 3'd0)
        preCnt[i] <= 3'(preCnt[i] - 3'd1);

    always_ff @(posedge clk or negedge rstSync_n)
      if (!rstSync_n)
        openRow[i] <= 10'h000;
      else if (openNow)
        openRow[i] <= row;

    always_ff @(posedge clk or negedge rstSync_n)
      if (!rstSync_n)
      begin
        colStrobeHi_n[i] <= 1'b1;
        colStrobeLo_n[i] <= 1'b1;
      end
      else
      begin
        // only the addressed bank drops CAS, so another bank's CAS precharge overlaps it
        colStrobeHi_n[i] <= !(next_state == S_CAS && bank == 2'(i) && reqBe[1]);
        colStrobeLo_n[i] <= !(next_state == S_CAS && bank == 2'(i) && reqBe[0]);
      end
  end

  // ---------------- pins and answer
  logic [17:0] dqMeta;
  logic [17:0] dqSync;
  always_ff @(posedge clk or negedge rstSync_n)
    if (!rstSync_n)
    begin
      dqMeta <= 18'h0_0000;
      dqSync <= 18'h0_0000;
    end
    else
    begin
      dqMeta <= dramDataIn;
      dqSync <= dqMeta;
    end

  always_ff @(posedge clk or negedge rstSync_n)
    if (!rstSync_n)
    begin
      dram_mux_address    <= 10'h000;
      dram_write_strobe_n <= 1'b1;
      dramDataOe          <= 1'b0;
      dramDataOut         <= 18'h0_0000;
      busHandoff          <= 1'b0;
      video_buffer_access_n <= 1'b1;
      bios_rom_select_n   <= 1'b1;
    end
    else
    begin
      dram_mux_address    <= next_state == S_CAS ? col : row;
      dram_write_strobe_n <= !(next_state == S_CAS && reqWrite);
      dramDataOe          <= next_state == S_CAS && reqWrite;
      dramDataOut         <= {^reqData[15:8], reqData[15:8], ^reqData[7:0], reqData[7:0]};
      busHandoff          <= state == S_DEC && !dramSel && !romSel && !wrDrop;
      video_buffer_access_n <= !(state == S_DEC && isVideo);
      bios_rom_select_n   <= !(state == S_DEC && romSel);
    end

  always_ff @(posedge clk or negedge rstSync_n)
    if (!rstSync_n)
      cpuResp <= '0;
    else
    begin
      cpuResp.ready <= next_state == S_DONE;
      if (state == S_CAS && next_state == S_DONE && !reqWrite)
      begin
        cpuResp.rdata     <= {dqSync[16:9], dqSync[7:0]};
        cpuResp.parityErr <= (reqBe[1] && ^dqSync[17:9]) || (reqBe[0] && ^dqSync[8:0]);
      end
      else if (state == S_DEC)
        cpuResp.parityErr <= 1'b0;
    end

  assign statusWord = {13'h0000, shadowOk, cfgErr, remapOn, total[23:16], 1'b0, state, ~rowStrobe_n};

  // ---------------- checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstSync_n);

  sequence takeNoPipe;
    state == S_IDLE && cpuReq.valid && !cpuPipelined;
  endsequence
  sequence takePipe;
    state == S_IDLE && cpuReq.valid && cpuPipelined;
  endsequence
  sequence decHit;
    state == S_DEC && dramSel && hit;
  endsequence

  wait_state_a: assert property (takeNoPipe |=> state == S_WAIT ##1 state == S_DEC)
    else $error("missing wait state for non-pipelined cycle");
  pipe_skip_a: assert property (takePipe |=> state == S_DEC)
    else $error("pipelined cycle was delayed");
  page_hit_a: assert property (decHit |=> state == S_CAS && !rowStrobe_n[bank])
    else $error("page hit did not go straight to column access");
  cas_ras_a: assert property (((~colStrobeHi_n | ~colStrobeLo_n) & rowStrobe_n) == 4'h0)
    else $error("column strobe without row strobe");
  precharge_a: assert property ($rose(rowStrobe_n[0]) |-> rowStrobe_n[0] [*3])
    else $error("bank 0 precharge too short");
  ras_limit_a: assert property (!rowStrobe_n[0] && rasCnt[0] == RW'(RAS_CYC) && !busy |=> rowStrobe_n[0])
    else $error("row held open past its limit");
  video_pass_a: assert property (state == S_DEC && isVideo |=> !video_buffer_access_n && busHandoff
                                 && cpuResp.ready && rowStrobe_n == $past(rowStrobe_n))
    else $error("video access not handed to the bus");
  remap_win_a: assert property (state == S_DEC && remapOn && a >= `DBMPI_MB1 && a < `DBMPI_REMAP_TOP
                                |-> dramSel && phys < `DBMPI_MB1 && phys >= `DBMPI_KB640)
    else $error("relocated window not mapped to DRAM");
  four_way_a: assert property (modeEff == M_IL4 && state == S_DEC |-> bank == phys[11:10])
    else $error("four-way bank select wrong");
  wr_protect_a: assert property (state == S_DEC && wrDrop |=> state == S_DONE ##1 colStrobeLo_n == 4'hF)
    else $error("write to protected shadow reached DRAM");
  nonpage_close_a: assert property (state == S_DONE && modeEff == M_NONPAGE |=> rowStrobe_n == 4'hF)
    else $error("non-page row left open");
endmodule

// file: common/dbmpi_consts.svh
`ifndef DBMPI_CONSTS_SVH
`define DBMPI_CONSTS_SVH

`define DBMPI_REG_CFG      8'h00
`define DBMPI_REG_SHADOW   8'h04
`define DBMPI_REG_STATUS   8'h08
`define DBMPI_CFG_RESET    32'h0000_0000
`define DBMPI_SHADOW_RESET 32'h0000_0000
`define DBMPI_CFG_MASK     32'h0000_07FF
`define DBMPI_SHADOW_MASK  32'h00FF_FFFF
`define DBMPI_CFG_MODE_LSB 0
`define DBMPI_CFG_TYPE_LSB 2
`define DBMPI_CFG_REMAP    10
`define DBMPI_SH_ROMOFF    0
`define DBMPI_SH_DRAMON    8
`define DBMPI_SH_WRPROT    16

`define DBMPI_KB640        24'h0A_0000
`define DBMPI_VID_LO       24'h0A_0000
`define DBMPI_BIOS_LO      24'h0C_0000
`define DBMPI_MB1          24'h10_0000
`define DBMPI_REMAP_TOP    24'h16_0000
`define DBMPI_SIZE_64K     24'h02_0000
`define DBMPI_SIZE_256K    24'h08_0000
`define DBMPI_SIZE_1M      24'h20_0000

`define DBMPI_CLK_NS       20
`define DBMPI_RAS_MAX_NS   10000
`define DBMPI_RAS_MAX_CYC  (`DBMPI_RAS_MAX_NS / `DBMPI_CLK_NS)
`define DBMPI_TRP_NS       60
`define DBMPI_TRP_CYC      ((`DBMPI_TRP_NS + `DBMPI_CLK_NS - 1) / `DBMPI_CLK_NS)
`define DBMPI_TRCD_NS      40
`define DBMPI_TRCD_CYC     ((`DBMPI_TRCD_NS + `DBMPI_CLK_NS - 1) / `DBMPI_CLK_NS)
`define DBMPI_TCAS_NS      40
`define DBMPI_TCAS_CYC     ((`DBMPI_TCAS_NS + `DBMPI_CLK_NS - 1) / `DBMPI_CLK_NS)
`define DBMPI_SYNC_LAT     2

`endif

// file: common/dbmpi_pkg.sv
package dbmpi_pkg;
  typedef enum logic [1:0] {M_NONPAGE = 2'b00, M_PAGE = 2'b01, M_IL2 = 2'b10, M_IL4 = 2'b11} dbmpi_mode_t;
  typedef enum logic [1:0] {D_NONE = 2'b00, D_64K = 2'b01, D_256K = 2'b10, D_1M = 2'b11} dbmpi_dtype_t;
  typedef enum logic [2:0]
  {
    S_IDLE = 3'b000,
    S_WAIT = 3'b001,
    S_DEC  = 3'b010,
    S_PRE  = 3'b011,
    S_RAS  = 3'b100,
    S_CAS  = 3'b101,
    S_DONE = 3'b110
  } dbmpi_state_t;
  typedef struct packed
  {
    logic        valid;
    logic        write;
    logic [1:0]  be;
    logic [23:1] addr;
    logic [15:0] wdata;
  } dbmpi_req_t;
  typedef struct packed
  {
    logic        ready;
    logic        parityErr;
    logic [15:0] rdata;
  } dbmpi_resp_t;
endpackage

// file: sim/dbmpi_dram_model.sv
module dbmpi_dram_model
  import dbmpi_pkg::*;
(
  input  wire logic        clk,
  input  wire logic [3:0]  rowStrobe_n,
  input  wire logic [3:0]  colStrobeHi_n,
  input  wire logic [3:0]  colStrobeLo_n,
  input  wire logic [9:0]  dram_mux_address,
  input  wire logic        dram_write_strobe_n,
  input  wire logic [17:0] dramDataOut,
  input  wire logic        dramDataOe,
  output logic      [17:0] dramDataIn,
  output int               badParity
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [17:0] mem [int];
  logic [9:0]  row [4];
  logic [3:0]  prevRas = 4'hF;
  logic        tog = 1'b0;
  logic [17:0] w;
  int          k;
  initial badParity = 0;
  always @(posedge clk)
  begin
    tog <= ~tog;
    prevRas <= rowStrobe_n;
    for (int b = 0; b < 4; b++)
    begin
      if (prevRas[b] && !rowStrobe_n[b])
        row[b] <= dram_mux_address;
      k = {b[1:0], row[b], dram_mux_address};
      // data only lands while the controller drives the lines
      if (!dram_write_strobe_n && dramDataOe && !(colStrobeHi_n[b] && colStrobeLo_n[b]))
      begin
        w = mem.exists(k) ? mem[k] : 18'h0;
        if (!colStrobeHi_n[b])
          w[17:9] = dramDataOut[17:9];
        if (!colStrobeLo_n[b])
          w[8:0] = dramDataOut[8:0];
        if ((!colStrobeHi_n[b] && ^dramDataOut[17:9]) || (!colStrobeLo_n[b] && ^dramDataOut[8:0]))
          badParity++;
        mem[k] = w;
      end
    end
  end
  // released lines toggle each cycle so a late sample cannot match by luck
  always_comb
  begin
    dramDataIn = {18{tog}} ^ 18'h2AAAA;
    for (int b = 0; b < 4; b++)
      if (dram_write_strobe_n && !colStrobeLo_n[b] && mem.exists({b[1:0], row[b], dram_mux_address}))
        dramDataIn = mem[{b[1:0], row[b], dram_mux_address}];
  end
endmodule

// file: sim/test_dram_bank_map_page_interleave.sv
`include "dbmpi_consts.svh"
module test_dram_bank_map_page_interleave
  import dbmpi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] CFG = `DBMPI_REG_CFG;
  localparam logic [7:0] SHD = `DBMPI_REG_SHADOW;
  localparam logic [7:0] T1M = {D_NONE, D_NONE, D_256K, D_256K};
  localparam logic [7:0] T512 = {D_NONE, D_NONE, D_NONE, D_256K};
  localparam logic [7:0] T15 = {D_NONE, D_256K, D_256K, D_256K};
  localparam logic [7:0] T2M = {D_256K, D_256K, D_256K, D_256K};
  localparam logic [7:0] STS = `DBMPI_REG_STATUS;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready, pslverr, busHandoff, video_buffer_access_n, bios_rom_select_n;
  logic        cpuPipelined = 1'b1;
  dbmpi_req_t  cpuReq = '0;
  dbmpi_resp_t cpuResp;
  logic [3:0]  rowStrobe_n, colStrobeHi_n, colStrobeLo_n;
  logic [3:0]  prevRas = 4'hF;
  logic [9:0]  dram_mux_address;
  logic        dram_write_strobe_n, dramDataOe, hand, vid, rom, er;
  logic [17:0] dramDataOut, dramDataIn;
  logic [15:0] d;
  int          failCount = 0, checks = 0, badParity, rasFalls = 0, lastRas = 9, cyc = 0, n1, n2, rf;

  always #10 clk = ~clk;

  dbmpi_dram_ctrl dbmpi_dram_ctrl_inst (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpuReq(cpuReq), .cpuPipelined(cpuPipelined), .cpuResp(cpuResp), .busHandoff(busHandoff),
    .video_buffer_access_n(video_buffer_access_n), .bios_rom_select_n(bios_rom_select_n),
    .rowStrobe_n(rowStrobe_n), .colStrobeHi_n(colStrobeHi_n), .colStrobeLo_n(colStrobeLo_n),
    .dram_mux_address(dram_mux_address), .dram_write_strobe_n(dram_write_strobe_n),
    .dramDataOut(dramDataOut), .dramDataOe(dramDataOe), .dramDataIn(dramDataIn));

  dbmpi_dram_model dbmpi_dram_model_inst (.clk(clk), .rowStrobe_n(rowStrobe_n),
    .colStrobeHi_n(colStrobeHi_n), .colStrobeLo_n(colStrobeLo_n), .dram_mux_address(dram_mux_address),
    .dram_write_strobe_n(dram_write_strobe_n), .dramDataOut(dramDataOut), .dramDataOe(dramDataOe),
    .dramDataIn(dramDataIn), .badParity(badParity));

  // row opens counted here so page hits can be told from misses
  always @(posedge clk)
  begin
    prevRas <= rowStrobe_n;
    for (int b = 0; b < 4; b++)
      if (prevRas[b] && !rowStrobe_n[b])
      begin
        rasFalls++;
        lastRas = b;
      end
  end

  task automatic printVerdict();
    $display("checks %0d mismatches %0d", checks, failCount);
    if (failCount == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failCount++;
      printVerdict();
    end
  end

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      failCount++;
      $display("unexpected %s: expected %h seen %h", s, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // pready is read as sampled at the edge, before the design updates it
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cpu(input logic [23:0] a, input logic wr, input logic [15:0] wd, output int n);
    @(posedge clk);
    cpuReq <= '{1'b1, wr, 2'b11, a[23:1], wd};
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (cpuResp.ready !== 1'b1);
    d = cpuResp.rdata;
    hand = busHandoff;
    vid = video_buffer_access_n;
    rom = bios_rom_select_n;
    cpuReq.valid <= 1'b0;
  endtask

  function automatic logic [31:0] cw(dbmpi_mode_t m, logic [7:0] t, logic r);
    return {21'h0, r, t, m};
  endfunction

  task automatic tRegs();
    apb(0, CFG, 0);
    chk("cfg reset", `DBMPI_CFG_RESET, rd);
    apb(1, CFG, 32'hFFFF_FFFF);
    apb(0, CFG, 0);
    chk("cfg mask", `DBMPI_CFG_MASK, rd);
    apb(0, 8'h0C, 0);
    chk("unmapped err", 1, er);
    chk("unmapped data", 0, rd);
  endtask

  task automatic tLinear();
    apb(1, CFG, cw(M_NONPAGE, T1M, 0));
    cpu(24'h07_FFFE, 1, 16'hA55A, n1);
    chk("bank below 512K", 0, lastRas);
    cpu(24'h08_0000, 1, 16'h0FF0, n1);
    chk("bank at 512K", 1, lastRas);
    cpu(24'h07_FFFE, 0, 0, n1);
    chk("bank0 word", 16'hA55A, d);
    cpu(24'h08_0000, 0, 0, n1);
    chk("bank1 word", 16'h0FF0, d);
    chk("parity flag", 0, cpuResp.parityErr);
  endtask

  task automatic tInterleave();
    apb(1, CFG, cw(M_IL2, T1M, 0));
    cpu(24'h00_0000, 1, 16'h1111, n1);
    chk("il bank low", 0, lastRas);
    cpu(24'h00_0400, 1, 16'h2222, n1);
    chk("il bank 1KB", 1, lastRas);
    rf = rasFalls;
    cpu(24'h00_0000, 0, 0, n1);
    chk("il row kept", rf, rasFalls);
    chk("il data", 16'h1111, d);
    apb(1, CFG, cw(M_IL4, T2M, 0));
    cpu(24'h00_0800, 1, 16'h5AA5, n1);
    chk("il4 bank 2", 2, lastRas);
    cpu(24'h00_0C00, 1, 16'h6969, n1);
    chk("il4 bank 3", 3, lastRas);
    cpu(24'h00_0800, 0, 0, n1);
    chk("il4 data", 16'h5AA5, d);
  endtask

  task automatic tPage();
    apb(1, CFG, cw(M_PAGE, T1M, 0));
    cpu(24'h00_0200, 1, 16'h3C3C, n1);
    rf = rasFalls;
    cpu(24'h00_0202, 1, 16'h4B4B, n2);
    chk("hit no row open", rf, rasFalls);
    chk("hit faster", 1, n2 < n1);
    cpu(24'h00_0200, 0, 0, n2);
    chk("hit read", 16'h3C3C, d);
    cpu(24'h04_0000, 0, 0, n2);
    chk("miss reopens", rf + 1, rasFalls);
    repeat (`DBMPI_RAS_MAX_CYC + 20) @(posedge clk);
    chk("row timeout", 1, rowStrobe_n[0]);
  endtask

  task automatic tWait();
    cpu(24'h0A_0000, 0, 0, n1);
    chk("video select", 0, vid);
    chk("video handoff", 1, hand);
    @(posedge clk);
    cpuPipelined <= 1'b0;
    cpu(24'h0A_0000, 0, 0, n2);
    chk("wait state", n1 + 1, n2);
    @(posedge clk);
    cpuPipelined <= 1'b1;
  endtask

  task automatic tRemap();
    apb(1, CFG, cw(M_PAGE, T1M, 0));
    cpu(24'h10_0000, 0, 0, n1);
    chk("no remap", 1, hand);
    apb(1, CFG, cw(M_PAGE, T1M, 1));
    cpu(24'h15_FFFE, 1, 16'hC3C3, n1);
    cpu(24'h15_FFFE, 0, 0, n1);
    chk("remap local", 0, hand);
    chk("remap data", 16'hC3C3, d);
    cpu(24'h0A_0000, 0, 0, n1);
    chk("remap video", 0, vid);
    cpu(24'h09_FFFE, 0, 0, n1);
    chk("low dram", 0, hand);
    apb(1, CFG, cw(M_PAGE, T15, 0));
    cpu(24'h10_0000, 0, 0, n1);
    chk("ext dram", 0, hand);
    cpu(24'h0E_0000, 0, 0, n1);
    chk("hidden window", 0, rom);
  endtask

  task automatic tConfig();
    apb(1, CFG, cw(M_PAGE, {D_NONE, D_NONE, D_64K, D_256K}, 0));
    apb(0, STS, 0);
    chk("64K beside 256K ok", 0, rd[17]);
    chk("64K total", 8'h0A, rd[15:8]);
    apb(1, CFG, cw(M_PAGE, {D_NONE, D_NONE, D_64K, D_1M}, 0));
    apb(0, STS, 0);
    chk("64K beside 1M err", 1, rd[17]);
    apb(1, CFG, cw(M_IL2, T15, 0));
    apb(0, STS, 0);
    chk("unequal pair err", 1, rd[17]);
    cpu(24'h08_0000, 1, 16'h7E7E, n1);
    chk("fallback linear", 1, lastRas);
  endtask

  task automatic tShadow();
    apb(1, CFG, cw(M_PAGE, T1M, 0));
    cpu(24'h0F_8000, 0, 0, n1);
    chk("rom select", 0, rom);
    apb(1, SHD, 32'h0000_0080);
    apb(1, SHD, 32'h0000_8080);
    cpu(24'h0F_8000, 1, 16'h5A5A, n1);
    cpu(24'h0F_8000, 0, 0, n1);
    chk("shadow rom off", 1, rom);
    chk("shadow data", 16'h5A5A, d);
    apb(1, SHD, 32'h0080_8080);
    cpu(24'h0F_8000, 1, 16'h1111, n1);
    cpu(24'h0F_8000, 0, 0, n1);
    chk("write protect", 16'h5A5A, d);
    apb(1, CFG, cw(M_PAGE, T512, 0));
    apb(1, SHD, 32'h0000_8000);
    cpu(24'h0F_8000, 0, 0, n1);
    chk("shadow small", 0, rom);
  endtask

  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    tRegs();
    tLinear();
    tInterleave();
    tConfig();
    tPage();
    tWait();
    tRemap();
    tShadow();
    chk("parity", 0, badParity);
    printVerdict();
  end
endmodule
